// file: design/wake_defs.svh
`ifndef WAKE_DEFS_SVH
`define WAKE_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_WAKE_EVENT_CONTROL 8'h00
`define OFS_POWER_MGMT_CONTROL 8'h04
`define OFS_STATION_LO         8'h08
`define OFS_STATION_HI         8'h0c
`define OFS_RECEIVE_FILTER     8'h10
`define OFS_IRQ_STATUS         8'h14
`define OFS_IRQ_CLEAR          8'h18
`define OFS_IRQ_ENABLE         8'h1c
`define OFS_PATTERN_RESET      8'h20
`define OFS_PATTERN_DATA       8'h24
`define OFS_PATTERN_LENGTH     8'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_PAT_EN    0
`define BIT_ADDR_EN   1
`define BIT_LINK_EN   2
`define BIT_PAT_FLAG  4
`define BIT_ADDR_FLAG 5
`define BIT_LINK_FLAG 6
`define BIT_PME_EN    8
`define BIT_PIN_LEVEL 14
`define BIT_PME_STAT  15
`define BIT_FLT_UNI   0
`define BIT_FLT_MULTI 1
`define BIT_FLT_BCAST 2
`define BIT_FLT_ALL   3

// ----------------------------------------
// Codes, reset values, constants
// ----------------------------------------
`define PSTATE_D0      2'h0
`define RST_WAKE_CTRL  3'h0
`define RST_FILTER     4'h5
`define PAT_END        8'h00
`define SYNC_BYTE      8'hff
`define SYNC_RUN       3'h6
`define ADDR_REPEATS   5'h10
`define CRC_INIT       32'hffffffff
`define CRC_POLY_REFL  32'hedb88320

`endif

// file: design/wake_pkg.sv
`default_nettype none
package wake_pkg;
  typedef enum logic [2:0] {
    CK_IDLE   = 3'b000,
    CK_OFFSET = 3'b001,
    CK_COUNT  = 3'b010,
    CK_DATA   = 3'b011,
    CK_CRC    = 3'b100,
    CK_DONE   = 3'b101
  } check_state_t;
endpackage
`default_nettype wire

// file: design/wake_event_detector.sv
`include "wake_defs.svh"
`default_nettype none
module wake_event_detector #(
  parameter int PAT_BYTES = 16384,
  parameter int RX_BYTES  = 32768
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Receive MAC byte stream
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_sof,
  input  wire logic        i_rx_eof,
  input  wire logic        i_rx_good,
  // Link monitor pin
  input  wire logic        i_link_up,
  // Open-drain wake request pin
  input  wire logic        i_wake_request_pin_in,
  output logic             o_wake_request_pin_out,
  output logic             o_wake_request_pin_oe,
  // Interrupt
  output logic             o_irq
);
  import wake_pkg::*;

  localparam int PW = $clog2(PAT_BYTES);
  localparam int RW = $clog2(RX_BYTES);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Store sizes
  logic [7:0]    pat_mem [PAT_BYTES];
  logic [7:0]    rx_mem  [RX_BYTES];

  logic [2:0]    wake_en;
  logic [2:0]    wake_flag;
  logic [1:0]    power_state;
  logic          pm_event_enable;
  logic          pm_event_status_flag;
  logic [47:0]   station_mac_address;
  logic [3:0]    receive_filter_mode;
  logic [2:0]    irq_status;
  logic [2:0]    irq_enable;
  logic [PW:0]   pat_len;
  logic          ack;
  logic          wr_fire;
  logic [31:0]   wmask;
  logic [31:0]   wval;
  logic [2:0]    ev;
  logic          sleeping;
  logic [1:0]    link_sync;
  logic [1:0]    pin_sync;
  logic          link_ref;

  assign sleeping = power_state != `PSTATE_D0;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // One wait cycle: read data loads on the first edge, writes land on the second
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  assign wr_fire = i_avs_write & ack;
  assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                  {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign wval = i_avs_writedata & wmask;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs_read | i_avs_write) & ~ack;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if ((i_avs_read | i_avs_write) & ~ack) begin
      o_avs_readdata <= 32'h00000000;
      if (i_avs_address == `OFS_WAKE_EVENT_CONTROL) begin
        o_avs_readdata[`BIT_LINK_FLAG:`BIT_PAT_FLAG] <= wake_flag;
        o_avs_readdata[`BIT_LINK_EN:`BIT_PAT_EN] <= wake_en;
      end else if (i_avs_address == `OFS_POWER_MGMT_CONTROL) begin
        o_avs_readdata[1:0] <= power_state;
        o_avs_readdata[`BIT_PME_EN] <= pm_event_enable;
        o_avs_readdata[`BIT_PIN_LEVEL] <= pin_sync[1];
        o_avs_readdata[`BIT_PME_STAT] <= pm_event_status_flag;
      end else if (i_avs_address == `OFS_STATION_LO) begin
        o_avs_readdata <= station_mac_address[31:0];
      end else if (i_avs_address == `OFS_STATION_HI) begin
        o_avs_readdata[15:0] <= station_mac_address[47:32];
      end else if (i_avs_address == `OFS_RECEIVE_FILTER) begin
        o_avs_readdata[3:0] <= receive_filter_mode;
      end else if (i_avs_address == `OFS_IRQ_STATUS) begin
        o_avs_readdata[2:0] <= irq_status;
      end else if (i_avs_address == `OFS_IRQ_ENABLE) begin
        o_avs_readdata[2:0] <= irq_enable;
      end else if (i_avs_address == `OFS_PATTERN_LENGTH) begin
        o_avs_readdata[PW:0] <= pat_len;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_en             <= `RST_WAKE_CTRL;
      power_state         <= `PSTATE_D0;
      pm_event_enable     <= 1'b0;
      station_mac_address <= 48'h000000000000;
      receive_filter_mode <= `RST_FILTER;
      irq_enable          <= 3'h0;
    end else if (wr_fire) begin
      if (i_avs_address == `OFS_WAKE_EVENT_CONTROL) begin
        if (i_avs_byteenable[0])
          wake_en <= i_avs_writedata[`BIT_LINK_EN:`BIT_PAT_EN];
      end else if (i_avs_address == `OFS_POWER_MGMT_CONTROL) begin
        if (i_avs_byteenable[0])
          power_state <= i_avs_writedata[1:0];
        if (i_avs_byteenable[1])
          pm_event_enable <= i_avs_writedata[`BIT_PME_EN];
      end else if (i_avs_address == `OFS_STATION_LO) begin
        station_mac_address[31:0] <=
          (station_mac_address[31:0] & ~wmask) | wval;
      end else if (i_avs_address == `OFS_STATION_HI) begin
        station_mac_address[47:32] <=
          (station_mac_address[47:32] & ~wmask[15:0]) | wval[15:0];
      end else if (i_avs_address == `OFS_RECEIVE_FILTER) begin
        if (i_avs_byteenable[0])
          receive_filter_mode <= i_avs_writedata[3:0];
      end else if (i_avs_address == `OFS_IRQ_ENABLE) begin
        if (i_avs_byteenable[0])
          irq_enable <= i_avs_writedata[2:0];
      end
    end
  end

  // ----------------------------------------
  // Pattern store loading
  // ----------------------------------------
  // Reset then append pseudo-frame bytes
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pat_len <= '0;
    end else if (wr_fire && i_avs_address == `OFS_PATTERN_RESET) begin
      pat_len <= '0;
    end else if (wr_fire && i_avs_address == `OFS_PATTERN_DATA &&
                 i_avs_byteenable[0] && pat_len < (PW+1)'(PAT_BYTES)) begin
      pat_len <= pat_len + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (wr_fire && i_avs_address == `OFS_PATTERN_DATA &&
        i_avs_byteenable[0] && pat_len < (PW+1)'(PAT_BYTES))
      pat_mem[pat_len[PW-1:0]] <= i_avs_writedata[7:0];
  end

  // ----------------------------------------
  // Receive side: store, filter, repetition scan
  // ----------------------------------------
  check_state_t  ck_state;
  logic          rx_take;
  logic          rx_on;
  logic [RW:0]   fr_len;
  logic [47:0]   da;
  logic [2:0]    ff_run;
  logic          in_seq;
  logic [2:0]    seq_idx;
  logic [4:0]    seq_rep;
  logic          rep_seen;
  logic [7:0]    mac_byte;
  logic          flt_pass;
  logic          frame_end;

  // Frames arriving while the pattern walk runs are not checked
  assign rx_take = i_rx_valid & (rx_on | (i_rx_sof & ck_state == CK_IDLE));
  assign frame_end = rx_take & i_rx_eof & i_rx_good & sleeping;
  assign mac_byte = station_mac_address[47 - 8*seq_idx -: 8];

  always_comb begin
    flt_pass = receive_filter_mode[`BIT_FLT_ALL];
    if (receive_filter_mode[`BIT_FLT_UNI] && da == station_mac_address)
      flt_pass = 1'b1;
    if (receive_filter_mode[`BIT_FLT_BCAST] && &da)
      flt_pass = 1'b1;
    if (receive_filter_mode[`BIT_FLT_MULTI] && da[40] && ~&da)
      flt_pass = 1'b1;
  end

  always_ff @(posedge i_clk_sys) begin
    if (rx_take && i_rx_sof)
      rx_mem[0] <= i_rx_data;
    else if (rx_take && fr_len < (RW+1)'(RX_BYTES))
      rx_mem[fr_len[RW-1:0]] <= i_rx_data;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_on  <= 1'b0;
      fr_len <= '0;
      da     <= 48'h000000000000;
    end else if (rx_take) begin
      rx_on  <= ~i_rx_eof;
      fr_len <= i_rx_sof ? (RW+1)'(1) : fr_len + 1'b1;
      if (i_rx_sof)
        da <= {i_rx_data, 40'h0000000000};
      else if (fr_len < (RW+1)'(6))
        da[47 - 8*fr_len[2:0] -: 8] <= i_rx_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ff_run   <= 3'h0;
      in_seq   <= 1'b0;
      seq_idx  <= 3'h0;
      seq_rep  <= 5'h00;
      rep_seen <= 1'b0;
    end else if (rx_take) begin
      ff_run <= (i_rx_data == `SYNC_BYTE) ?
        ((ff_run == `SYNC_RUN) ? ff_run : ff_run + 1'b1) : 3'h0;
      if (i_rx_sof) begin
        in_seq   <= 1'b0;
        seq_idx  <= 3'h0;
        seq_rep  <= 5'h00;
        rep_seen <= 1'b0;
      end else if (in_seq && i_rx_data == mac_byte) begin
        seq_idx <= (seq_idx == 3'h5) ? 3'h0 : seq_idx + 1'b1;
        if (seq_idx == 3'h5) begin
          seq_rep <= seq_rep + 1'b1;
          if (seq_rep == `ADDR_REPEATS - 5'h01) begin
            rep_seen <= 1'b1;
            in_seq   <= 1'b0;
          end
        end
      // Start only after six sync bytes
      end else if (ff_run == `SYNC_RUN && seq_idx == 3'h0 &&
                   i_rx_data == station_mac_address[47:40]) begin
        in_seq  <= 1'b1;
        seq_idx <= 3'h1;
        seq_rep <= 5'h00;
      end else begin
        in_seq  <= 1'b0;
        seq_idx <= 3'h0;
        seq_rep <= 5'h00;
      end
    end
  end

  // ----------------------------------------
  // Pattern walk and CRC
  // ----------------------------------------
  logic [PW:0]   pp;
  logic [RW:0]   fp;
  logic [7:0]    rem;
  logic [1:0]    kb;
  logic [31:0]   crc;
  logic          miss;
  logic          any_hit;
  logic [RW:0]   chk_len;
  logic [7:0]    pbyte;
  logic [31:0]   crc_fin;

  assign pbyte = pat_mem[pp[PW-1:0]];
  assign crc_fin = ~crc;

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `CRC_POLY_REFL) : (r >> 1);
    return r;
  endfunction

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ck_state <= CK_IDLE;
      pp <= '0;
      fp <= '0;
      rem <= 8'h00;
      kb <= 2'h0;
      crc <= `CRC_INIT;
      miss <= 1'b0;
      any_hit <= 1'b0;
      chk_len <= '0;
    end else begin
      case (ck_state)
        CK_IDLE: begin
          pp <= '0;
          fp <= '0;
          crc <= `CRC_INIT;
          miss <= 1'b0;
          any_hit <= 1'b0;
          chk_len <= fr_len + 1'b1;
          if (frame_end && wake_en[`BIT_PAT_EN] && flt_pass &&
              pat_len != '0)
            ck_state <= CK_OFFSET;
        end
        CK_OFFSET: begin
          pp <= pp + 1'b1;
          kb <= 2'h0;
          if (pp >= pat_len) begin
            ck_state <= CK_DONE;
          end else if (pbyte == `PAT_END) begin
            ck_state <= CK_CRC;
          end else begin
            fp <= fp + (RW+1)'(pbyte);
            ck_state <= CK_COUNT;
          end
        end
        CK_COUNT: begin
          pp <= pp + 1'b1;
          rem <= pbyte;
          ck_state <= (pbyte == 8'h00) ? CK_OFFSET : CK_DATA;
        end
        CK_DATA: begin
          crc <= crc_byte(crc, rx_mem[fp[RW-1:0]]);
          if (fp >= chk_len)
            miss <= 1'b1;
          fp <= fp + 1'b1;
          rem <= rem - 1'b1;
          if (rem == 8'h01)
            ck_state <= CK_OFFSET;
        end
        CK_CRC: begin
          pp <= pp + 1'b1;
          kb <= kb + 1'b1;
          // Compare with stored CRC, low byte first
          if (pp >= pat_len || pbyte != crc_fin[8*kb +: 8])
            miss <= 1'b1;
          if (kb == 2'h3) begin
            if (!miss && pp < pat_len && pbyte == crc_fin[31:24])
              any_hit <= 1'b1;
            fp <= '0;
            crc <= `CRC_INIT;
            miss <= 1'b0;
            ck_state <= CK_OFFSET;
          end
        end
        CK_DONE: ck_state <= CK_IDLE;
        default: ck_state <= CK_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Link monitor
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_sync <= 2'h0;
      pin_sync  <= 2'h3;
    end else begin
      link_sync <= {link_sync[0], i_link_up};
      pin_sync  <= {pin_sync[0], i_wake_request_pin_in};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_ref <= 1'b0;
    end else if (wr_fire && i_avs_address == `OFS_WAKE_EVENT_CONTROL &&
                 i_avs_byteenable[0] && i_avs_writedata[`BIT_LINK_EN] &&
                 !wake_en[`BIT_LINK_EN]) begin
      link_ref <= link_sync[1];
    end
  end

  // ----------------------------------------
  // Events, flags, wake pin, interrupt
  // ----------------------------------------
  // Per-source enables
  assign ev[0] = sleeping & wake_en[`BIT_PAT_EN] & ck_state == CK_DONE &
                 any_hit;
  assign ev[1] = frame_end & wake_en[`BIT_ADDR_EN] & rep_seen &
                 (flt_pass | &da);
  // Link change before D0 or disable
  assign ev[2] = sleeping & wake_en[`BIT_LINK_EN] & link_sync[1] != link_ref;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_flag <= 3'h0;
    end else begin
      wake_flag <= (wake_flag & ~((wr_fire && i_avs_address ==
                   `OFS_WAKE_EVENT_CONTROL && i_avs_byteenable[0]) ?
                   i_avs_writedata[`BIT_LINK_FLAG:`BIT_PAT_FLAG] : 3'h0))
                   | ev;
    end
  end

  // Status flag, write one to clear
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pm_event_status_flag <= 1'b0;
    end else if (|ev) begin
      pm_event_status_flag <= 1'b1;
    end else if (wr_fire && i_avs_address == `OFS_POWER_MGMT_CONTROL &&
                 i_avs_byteenable[1] && i_avs_writedata[`BIT_PME_STAT]) begin
      pm_event_status_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status & ~((wr_fire && i_avs_address ==
                    `OFS_IRQ_CLEAR && i_avs_byteenable[0]) ?
                    i_avs_writedata[2:0] : 3'h0)) | ev;
    end
  end

  assign o_irq = |(irq_status & irq_enable);

  // Pin driven low only with event enable
  assign o_wake_request_pin_out = 1'b0;
  assign o_wake_request_pin_oe  = pm_event_status_flag & pm_event_enable;

endmodule
`default_nettype wire

// file: bench/wake_rx_model.sv
`default_nettype none
module wake_rx_model (
  // Clock
  input  wire logic       i_clk_sys,
  // Receive byte stream
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_sof,
  output logic            o_rx_eof,
  output logic            o_rx_good,
  // Link monitor
  output logic            o_link_up
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_rx_sof   = 1'b0;
    o_rx_eof   = 1'b0;
    o_rx_good  = 1'b0;
    o_link_up  = 1'b1;
  end

  // Toggled idle data exposes stale bytes
  task automatic idle();
    @(posedge i_clk_sys);
    o_rx_valid <= 1'b0;
    o_rx_sof   <= 1'b0;
    o_rx_eof   <= 1'b0;
    o_rx_good  <= 1'b0;
    o_rx_data  <= ~o_rx_data;
  endtask

  // Sends q; slow stalls after each fourth byte
  task automatic send(input logic good, input logic slow);
    foreach (q[i]) begin
      @(posedge i_clk_sys);
      o_rx_valid <= 1'b1;
      o_rx_data  <= q[i];
      o_rx_sof   <= (i == 0);
      o_rx_eof   <= (i == q.size() - 1);
      o_rx_good  <= good && (i == q.size() - 1);
      if (slow && i % 4 == 3) begin
        idle();
      end
    end
    idle();
  endtask

  task automatic set_link(input logic v);
    @(posedge i_clk_sys);
    o_link_up <= v;
  endtask
endmodule
`default_nettype wire

// file: bench/wake_event_detector_sva.sv
`include "wake_defs.svh"
`default_nettype none
module wake_event_detector_sva (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  // Register bus
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // Receive stream and link
  input wire logic        i_rx_valid,
  input wire logic [7:0]  i_rx_data,
  input wire logic        i_rx_sof,
  input wire logic        i_rx_eof,
  input wire logic        i_rx_good,
  input wire logic        i_link_up,
  // Wake pin and interrupt
  input wire logic        i_wake_request_pin_in,
  input wire logic        o_wake_request_pin_out,
  input wire logic        o_wake_request_pin_oe,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  logic       wr_done;
  logic [1:0] pstate;
  logic       pme_en;
  logic       link_en;
  assign wr_done = i_avs_write && !o_avs_waitrequest;

  // ------------------------------------------
  // Shadow of host power settings and link enable
  // ------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pstate  <= 2'h0;
      pme_en  <= 1'b0;
      link_en <= 1'b0;
    end else if (wr_done && i_avs_address == `OFS_POWER_MGMT_CONTROL) begin
      if (i_avs_byteenable[0]) pstate <= i_avs_writedata[1:0];
      if (i_avs_byteenable[1]) pme_en <= i_avs_writedata[8];
    end else if (wr_done && i_avs_address == `OFS_WAKE_EVENT_CONTROL &&
                 i_avs_byteenable[0]) begin
      link_en <= i_avs_writedata[2];
    end
  end

  sequence s_pm_write;
    wr_done && i_avs_address == `OFS_POWER_MGMT_CONTROL &&
      i_avs_byteenable[1];
  endsequence

  sequence s_link_flip;
    pstate != `PSTATE_D0 && pme_en && link_en && $changed(i_link_up);
  endsequence

  // ------------------------------------------
  // Assertions
  // ------------------------------------------
  a_req_waits_once: assert property (
    $rose(i_avs_read || i_avs_write) |->
      o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus request not answered after one wait");
  a_read_stands: assert property (
    !$past(i_avs_read || i_avs_write) |-> $stable(o_avs_readdata))
    else $error("read data moved without a request");
  a_pin_open_drain: assert property (!o_wake_request_pin_out)
    else $error("wake pin driven high");
  a_pin_released: assert property (
    s_pm_write ##0 !i_avs_writedata[8] |=> !o_wake_request_pin_oe)
    else $error("wake pin kept after event enable cleared");
  a_pin_sticky: assert property (
    o_wake_request_pin_oe && !(wr_done && i_avs_byteenable[1] &&
      i_avs_address == `OFS_POWER_MGMT_CONTROL) |=> o_wake_request_pin_oe)
    else $error("wake pin dropped without host action");
  a_pin_gated: assert property (
    o_wake_request_pin_oe |-> pme_en)
    else $error("wake pin while event enable clear");
  a_rise_asleep: assert property (
    $rose(o_wake_request_pin_oe) |-> pstate != `PSTATE_D0)
    else $error("wake pin raised in D0");
  a_link_wakes: assert property (
    s_link_flip |-> ##[1:6] o_wake_request_pin_oe)
    else $error("link change not signalled");
  a_irq_masked: assert property (
    wr_done && i_avs_address == `OFS_IRQ_ENABLE &&
      i_avs_writedata[2:0] == 3'h0 |=> !o_irq)
    else $error("interrupt while all enables clear");
endmodule

bind wake_event_detector wake_event_detector_sva u_sva (.*);
`default_nettype wire

// file: bench/wake_event_detector_tb.sv
`include "wake_defs.svh"
`default_nettype none
module wake_event_detector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [7:0]  address   = 8'h00;
  logic        read      = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rx_valid, rx_sof, rx_eof, rx_good, link_up;
  logic [7:0]  rx_data;
  logic        pin_oe, irq;
  int          miscompares = 0;
  int          num_checks  = 0;
  logic [7:0]  station [6] = '{8'h02, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5};

  always #5 clk_sys = ~clk_sys;

  wake_event_detector #(.PAT_BYTES(64), .RX_BYTES(256)) DUT (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_avs_address(address),
    .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitrequest), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_rx_sof(rx_sof), .i_rx_eof(rx_eof),
    .i_rx_good(rx_good), .i_link_up(link_up),
    .i_wake_request_pin_in(~pin_oe), .o_wake_request_pin_out(),
    .o_wake_request_pin_oe(pin_oe), .o_irq(irq));

  wake_rx_model m (
    .i_clk_sys(clk_sys), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_sof(rx_sof), .o_rx_eof(rx_eof), .o_rx_good(rx_good),
    .o_link_up(link_up));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string w);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, w, seen, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address   <= a;
    writedata <= d;
    read      <= !we;
    write     <= we;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] msk, e,
                    input string w);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & msk, e, w);
  endtask

  task automatic wait_pin(input logic e, input string w);
    int n;
    @(posedge clk_sys);
    for (n = 0; n < 100 && pin_oe !== 1'b1; n++) @(posedge clk_sys);
    check({31'h0, pin_oe}, {31'h0, e}, w);
  endtask

  task automatic chk_irq(input logic e, input string w);
    @(posedge clk_sys);
    check({31'h0, irq}, {31'h0, e}, w);
  endtask

  task automatic put(input logic [7:0] b, input int k);
    repeat (k) m.q.push_back(b);
  endtask

  task automatic put_addr(input int k);
    repeat (k) foreach (station[i]) m.q.push_back(station[i]);
  endtask

  function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
    logic [31:0] c;
    c = `CRC_INIT;
    foreach (b[i]) begin
      c ^= {24'h0, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY_REFL : c >> 1;
    end
    return ~c;
  endfunction

  task automatic t_reset_values();
    rd(`OFS_WAKE_EVENT_CONTROL, 32'h77, 32'h0, "wake control reset");
    rd(`OFS_POWER_MGMT_CONTROL, 32'hc103, 32'h4000, "power reset");
    rd(`OFS_RECEIVE_FILTER, 32'hf, 32'h5, "filter reset");
    wr(8'hfc, 32'hffffffff);
    rd(8'hfc, 32'hffffffff, 32'h0, "unmapped");
    wr(`OFS_STATION_LO, 32'hb2c3d4e5);
    wr(`OFS_STATION_HI, 32'h02a1);
    rd(`OFS_STATION_HI, 32'hffff, 32'h02a1, "station");
    $display("reset values done");
  endtask

  // da: 0 station, 1 broadcast, 2 other unicast
  task automatic t_addr(input logic [1:0] ps, input int da, nff, reps,
                        input logic e);
    m.q.delete();
    if (da == 0) put_addr(1);
    else put(da == 1 ? 8'hff : 8'h0a, 6);
    put(8'h5a, 8);
    put(8'hff, nff);
    put_addr(reps);
    put(8'h3c, 4);
    wr(`OFS_WAKE_EVENT_CONTROL, 32'h72);
    wr(`OFS_POWER_MGMT_CONTROL, {16'h0, 8'h81, 6'h0, ps});
    m.send(1'b1, da == 1);
    wait_pin(e, "addr repeat pin");
    rd(`OFS_WAKE_EVENT_CONTROL, 32'h20, {26'h0, e, 5'h0}, "addr flag");
    $display("addr repeat case done");
  endtask

  task automatic t_irq();
    rd(`OFS_IRQ_STATUS, 32'h7, 32'h2, "irq status");
    chk_irq(1'b0, "irq disabled");
    wr(`OFS_IRQ_ENABLE, 32'h2);
    chk_irq(1'b1, "irq raised");
    wr(`OFS_IRQ_ENABLE, 32'h0);
    chk_irq(1'b0, "irq masked");
    wr(`OFS_IRQ_ENABLE, 32'h2);
    wr(`OFS_IRQ_CLEAR, 32'h7);
    chk_irq(1'b0, "irq cleared");
    rd(`OFS_IRQ_STATUS, 32'h7, 32'h0, "irq status cleared");
    $display("interrupt test done");
  endtask

  task automatic t_pattern();
    logic [31:0] c;
    logic [7:0]  pat[$];
    m.q.delete();
    put_addr(2);
    put(8'h33, 20);
    c = crc_of(m.q[6:11]);
    pat = '{8'h01, 8'h04, `PAT_END, c[7:0], c[15:8], c[23:16], c[31:24],
            8'h06, 8'h06, `PAT_END, c[7:0], c[15:8], c[23:16], c[31:24]};
    wr(`OFS_PATTERN_RESET, 32'h0);
    foreach (pat[i]) wr(`OFS_PATTERN_DATA, {24'h0, pat[i]});
    rd(`OFS_PATTERN_LENGTH, 32'hffff, 32'd14, "pattern length");
    wr(`OFS_WAKE_EVENT_CONTROL, 32'h71);
    wr(`OFS_POWER_MGMT_CONTROL, 32'h8102);
    m.send(1'b1, 1'b1);
    wait_pin(1'b1, "pattern hit");
    rd(`OFS_WAKE_EVENT_CONTROL, 32'h10, 32'h10, "pattern flag");
    wr(`OFS_WAKE_EVENT_CONTROL, 32'h71);
    wr(`OFS_POWER_MGMT_CONTROL, 32'h8102);
    m.q[8] = 8'h00;
    m.send(1'b1, 1'b0);
    wait_pin(1'b0, "pattern miss");
    m.q[8] = station[2];
    m.q[0] = 8'h0a;
    m.send(1'b1, 1'b0);
    wait_pin(1'b0, "pattern filtered");
    $display("pattern test done");
  endtask

  task automatic t_link();
    wr(`OFS_POWER_MGMT_CONTROL, 32'h8103);
    wr(`OFS_WAKE_EVENT_CONTROL, 32'h74);
    wait_pin(1'b0, "link steady");
    m.set_link(1'b0);
    wait_pin(1'b1, "link change");
    rd(`OFS_WAKE_EVENT_CONTROL, 32'h40, 32'h40, "link flag");
    rd(`OFS_POWER_MGMT_CONTROL, 32'hc000, 32'h8000, "status");
    wr(`OFS_POWER_MGMT_CONTROL, 32'h0003);
    wait_pin(1'b0, "pin released");
    wr(`OFS_WAKE_EVENT_CONTROL, 32'h70);
    wr(`OFS_POWER_MGMT_CONTROL, 32'h8100);
    wr(`OFS_WAKE_EVENT_CONTROL, 32'h74);
    m.set_link(1'b1);
    wait_pin(1'b0, "no wake in D0");
    $display("link test done");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset_values();
    t_addr(2'h3, 0, 6, 16, 1'b1);
    t_addr(2'h1, 1, 6, 16, 1'b1);
    t_addr(2'h2, 2, 6, 16, 1'b0);
    t_addr(2'h0, 0, 6, 16, 1'b0);
    t_addr(2'h3, 0, 5, 16, 1'b0);
    t_addr(2'h3, 0, 6, 15, 1'b0);
    t_irq();
    t_pattern();
    t_link();
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
